//--- include/acp_pkg.sv
// Constants and layouts shared by the configuration pin logic
package acp_pkg;
  // ***************************************************************
  // Widths
  // ***************************************************************
  localparam int DATA_W = 12;
  localparam int SER_WORD_W = 16;
  localparam int SER_ADDR_W = 4;
  localparam int SER_CNT_W = 5;
  localparam int PIN_N = 6;

  // ***************************************************************
  // Synchronised pin vector positions
  // ***************************************************************
  localparam int PIN_SEL = 0;
  localparam int PIN_SHARED_INV = 1;
  localparam int PIN_SHARED_OEA = 2;
  localparam int PIN_SHARED_PD = 3;
  localparam int PIN_REF = 4;
  localparam int PIN_OEB = 5;

  // ***************************************************************
  // APB register map (byte addresses)
  // ***************************************************************
  localparam logic [7:0] REG_CONTROL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_SERIAL_WORD = 8'h08;

  // Control fields
  localparam int CTRL_FREEZE = 0;
  localparam logic CTRL_FREEZE_RST = 1'b0;

  // Status fields
  localparam int ST_SEL = 0;
  localparam int ST_TWOS = 1;
  localparam int ST_TRI_A = 2;
  localparam int ST_TRI_B = 3;
  localparam int ST_PD = 4;
  localparam int ST_INT_REF = 5;

  // ***************************************************************
  // Serial configuration register
  // ***************************************************************
  localparam logic [SER_ADDR_W-1:0] SER_ADDR_CFG = 4'h0;
  localparam int SCFG_TWOS = 0;
  localparam int SCFG_TRI_A = 1;
  localparam int SCFG_PD = 2;
  localparam logic [2:0] SCFG_RST = 3'h0;
endpackage

//--- logic/acp_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module acp_pin_sync #(
  parameter int WIDTH = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);
  import acp_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } acp_sync_state_t;

  acp_sync_state_t st;
  acp_sync_state_t next_st;

  // Stage one feeds only stage two; a level is accepted once stages two and three agree
  always_comb begin
    next_st = st;
    next_st.s1 = pin;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.q[i] = st.s2[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level = st.q;
endmodule

//--- logic/acp_serial_cfg.sv
// Three-wire serial write port and its configuration register
`timescale 1ns/1ps
module acp_serial_cfg (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  input wire logic ser_enable_n,
  input wire logic ser_clock,
  input wire logic ser_data,
  output logic cfg_twos,
  output logic cfg_tri_a,
  output logic cfg_pd,
  output logic [acp_pkg::SER_WORD_W-1:0] last_word
);
  import acp_pkg::*;

  typedef struct packed {
    logic [SER_WORD_W-1:0] shift;
    logic [SER_CNT_W-1:0] count;
    logic clk_d;
    logic en_n_d;
    logic [2:0] cfg;
    logic [SER_WORD_W-1:0] word;
  } acp_ser_state_t;

  acp_ser_state_t st;
  acp_ser_state_t next_st;
  logic clk_rise;
  logic frame_end;

  assign clk_rise = ser_clock && !st.clk_d;
  assign frame_end = ser_enable_n && !st.en_n_d;

  // Shift on the serial clock inside a frame, commit a full word at frame end
  always_comb begin
    next_st = st;
    next_st.clk_d = ser_clock;
    next_st.en_n_d = ser_enable_n;
    if (clear) begin
      // Select held low wipes shift, count, config and word, so a stale partial word never survives
      next_st.shift = '0;
      next_st.count = '0;
      next_st.cfg = SCFG_RST;
      next_st.word = '0;
    end else begin
      if (!ser_enable_n && clk_rise) begin
        next_st.shift = {st.shift[SER_WORD_W-2:0], ser_data};
        if (st.count != SER_CNT_W'(SER_WORD_W)) begin
          next_st.count = st.count + SER_CNT_W'(1);
        end
      end
      if (frame_end) begin
        next_st.count = '0;
        // Short frames are dropped whole rather than half applied
        if (st.count == SER_CNT_W'(SER_WORD_W)) begin
          next_st.word = st.shift;
          if (st.shift[SER_WORD_W-1 -: SER_ADDR_W] == SER_ADDR_CFG) begin
            next_st.cfg = st.shift[2:0];
          end
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign cfg_twos = st.cfg[SCFG_TWOS];
  assign cfg_tri_a = st.cfg[SCFG_TRI_A];
  assign cfg_pd = st.cfg[SCFG_PD];
  assign last_word = st.word;
endmodule

//--- logic/acp_pin_mux.sv
// Configuration pin decoder, output coding and enables, APB status slave
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ps
module acp_pin_mux (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic interface_select,
  input wire logic top_bit_invert,
  input wire logic chan_a_enable_n,
  input wire logic standby_powerdown,
  input wire logic reference_source_choice,
  input wire logic chan_b_enable_n,
  input wire logic [acp_pkg::DATA_W-1:0] core_data_a,
  input wire logic [acp_pkg::DATA_W-1:0] core_data_b,
  output logic [acp_pkg::DATA_W-1:0] dout_a,
  output logic [acp_pkg::DATA_W-1:0] dout_b,
  output logic dout_a_oe,
  output logic dout_b_oe,
  output logic powerdown,
  output logic use_internal_ref
);
  import acp_pkg::*;

  // ***************************************************************
  // State
  // ***************************************************************
  typedef struct packed {
    logic [31:0] rdata;
    logic slverr;
    logic freeze;
    logic twos;
    logic tri_a;
    logic tri_b;
    logic pd;
    logic int_ref;
    logic [DATA_W-1:0] out_a;
    logic [DATA_W-1:0] out_b;
  } acp_top_state_t;

  acp_top_state_t st;
  acp_top_state_t next_st;
  logic [PIN_N-1:0] pins;
  logic [PIN_N-1:0] lvl;
  logic serial_mode;
  logic ser_twos;
  logic ser_tri_a;
  logic ser_pd;
  logic [SER_WORD_W-1:0] ser_word;
  logic setup;
  logic access;

  // Offset binary to two's complement is just the top bit flipped
  function automatic logic [DATA_W-1:0] apply_coding(input logic [DATA_W-1:0] w,
                                                      input logic twos);
    apply_coding = {w[DATA_W-1] ^ twos, w[DATA_W-2:0]};
  endfunction

  // ***************************************************************
  // Pin capture
  // ***************************************************************
  // All strap and board pins are asynchronous to pclk
  always_comb begin
    pins = '0;
    pins[PIN_SEL] = interface_select;
    pins[PIN_SHARED_INV] = top_bit_invert;
    pins[PIN_SHARED_OEA] = chan_a_enable_n;
    pins[PIN_SHARED_PD] = standby_powerdown;
    pins[PIN_REF] = reference_source_choice;
    pins[PIN_OEB] = chan_b_enable_n;
  end

  acp_pin_sync #(
    .WIDTH(PIN_N)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(pins),
    .level(lvl)
  );

  assign serial_mode = lvl[PIN_SEL];

  // Serial port sees the shared pins only while select is high
  acp_serial_cfg u_serial (
    .pclk(pclk),
    .presetn(presetn),
    .clear(!serial_mode),
    .ser_enable_n(lvl[PIN_SHARED_INV]),
    .ser_clock(lvl[PIN_SHARED_OEA]),
    .ser_data(lvl[PIN_SHARED_PD]),
    .cfg_twos(ser_twos),
    .cfg_tri_a(ser_tri_a),
    .cfg_pd(ser_pd),
    .last_word(ser_word)
  );

  assign setup = psel && !penable;
  assign access = psel && penable;

  // ***************************************************************
  // Decode and register update
  // ***************************************************************
  always_comb begin
    next_st = st;
    // Pin meaning follows the current select level every cycle
    if (serial_mode) begin
      next_st.twos = ser_twos;
      next_st.tri_a = ser_tri_a;
      next_st.pd = ser_pd;
    end else begin
      next_st.twos = lvl[PIN_SHARED_INV];
      next_st.tri_a = lvl[PIN_SHARED_OEA];
      next_st.pd = lvl[PIN_SHARED_PD];
    end
    next_st.tri_b = lvl[PIN_OEB];
    next_st.int_ref = lvl[PIN_REF];
    // Freeze holds the last words so software can read a stable pair on the board
    if (!st.freeze) begin
      next_st.out_a = apply_coding(core_data_a, st.twos);
      next_st.out_b = apply_coding(core_data_b, st.twos);
    end
    // Read data and error are prepared in the setup cycle for a zero-wait access
    if (setup) begin
      next_st.rdata = '0;
      next_st.slverr = 1'b0;
      unique case (paddr)
        REG_CONTROL: begin
          next_st.rdata[CTRL_FREEZE] = st.freeze;
        end
        REG_STATUS: begin
          next_st.rdata[ST_SEL] = serial_mode;
          next_st.rdata[ST_TWOS] = st.twos;
          next_st.rdata[ST_TRI_A] = st.tri_a;
          next_st.rdata[ST_TRI_B] = st.tri_b;
          next_st.rdata[ST_PD] = st.pd;
          next_st.rdata[ST_INT_REF] = st.int_ref;
        end
        REG_SERIAL_WORD: begin
          next_st.rdata[SER_WORD_W-1:0] = ser_word;
        end
        default: begin
          next_st.slverr = 1'b1;
        end
      endcase
      // Status and serial word are read only; writes there are refused
      if (pwrite && paddr != REG_CONTROL) begin
        next_st.slverr = 1'b1;
      end
    end
    if (access && pwrite && paddr == REG_CONTROL) begin
      next_st.freeze = pwdata[CTRL_FREEZE];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.freeze <= CTRL_FREEZE_RST;
    end else begin
      st <= next_st;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign pready = 1'b1;
  assign prdata = st.rdata;
  assign pslverr = st.slverr;
  assign dout_a = st.out_a;
  assign dout_b = st.out_b;
  assign dout_a_oe = !st.tri_a;
  assign dout_b_oe = !st.tri_b;
  assign powerdown = st.pd;
  assign use_internal_ref = st.int_ref;
endmodule

//--- bench/acp_pin_mux_chk.sv
// Port assertions for the configuration pin decoder
`timescale 1ns/1ps
module acp_pin_mux_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic interface_select,
  input wire logic chan_a_enable_n,
  input wire logic standby_powerdown,
  input wire logic reference_source_choice,
  input wire logic chan_b_enable_n,
  input wire logic dout_a_oe,
  input wire logic dout_b_oe,
  input wire logic powerdown,
  input wire logic use_internal_ref
);
  import acp_pkg::*;

  // ****************
  // Pin level and APB checks
  // ****************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Eight samples cover the filter latency with margin
  sequence s_ser;
    interface_select [*8];
  endsequence
  a_ref_follow: assert property ($stable(reference_source_choice) [*8]
    |-> use_internal_ref == reference_source_choice) else $error("ref level wrong");
  a_chb_enable: assert property ($stable(chan_b_enable_n) [*8]
    |-> dout_b_oe == !chan_b_enable_n) else $error("chan b enable wrong");
  a_cha_parallel: assert property ((!interface_select && $stable(chan_a_enable_n))
    [*8] |-> dout_a_oe == !chan_a_enable_n) else $error("chan a enable wrong");
  a_pd_parallel: assert property ((!interface_select && $stable(standby_powerdown)) [*8]
    |-> powerdown == standby_powerdown) else $error("powerdown wrong");
  // Serial clock and data toggles must not leak into the parallel outputs
  a_clk_serial: assert property (s_ser ##0 $changed(chan_a_enable_n)
    |=> $stable(dout_a_oe) [*3]) else $error("clock leaked");
  a_data_serial: assert property (s_ser ##0 $changed(standby_powerdown)
    |=> $stable(powerdown) [*3]) else $error("data leaked");
  a_apb_ready: assert property (psel |-> pready) else $error("no ready");
  // Only the control word takes writes; the error must stand in the access phase
  a_wr_refused: assert property (psel && !penable && pwrite && paddr != REG_CONTROL
    |=> pslverr) else $error("write not refused");
endmodule

bind acp_pin_mux acp_pin_mux_chk u_chk (.*);

//--- bench/acp_board.sv
// Board controller model driving the shared configuration pins
`timescale 1ns/1ps
module acp_board (
  input wire logic pclk,
  output logic interface_select,
  output logic top_bit_invert,
  output logic chan_a_enable_n,
  output logic standby_powerdown
);
  // Select starts high so the first parallel set gives the low pulse
  initial begin
    interface_select = 1'b1;
    top_bit_invert = 1'b1;
    chan_a_enable_n = 1'b0;
    standby_powerdown = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Frame enable idles high in serial mode
  task automatic set_par(input logic s, input logic v);
    hold(1);
    interface_select <= s;
    top_bit_invert <= v | s;
    chan_a_enable_n <= v;
    standby_powerdown <= v;
    hold(10);
  endtask
  // Slow edges, since the pin filter needs several stable samples
  task automatic frame(input logic [15:0] w, input int n);
    hold(1);
    top_bit_invert <= 1'b0;
    for (int i = 0; i < n; i++) begin
      chan_a_enable_n <= 1'b0;
      standby_powerdown <= w[15-i];
      hold(5);
      chan_a_enable_n <= 1'b1;
      hold(5);
    end
    chan_a_enable_n <= 1'b0;
    hold(5);
    top_bit_invert <= 1'b1;
    hold(12);
  endtask
endmodule

//--- bench/acp_pin_mux_test.sv
// Self-checking bench for the configuration pin decoder
`timescale 1ns/1ps
module acp_pin_mux_test;
  import acp_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic interface_select, top_bit_invert, chan_a_enable_n, standby_powerdown;
  logic reference_source_choice, chan_b_enable_n, dout_a_oe, dout_b_oe;
  logic powerdown, use_internal_ref;
  logic [DATA_W-1:0] core_data_a, core_data_b, dout_a, dout_b;
  int err_count, n_checks;
  acp_pin_mux u_dut (.*);
  acp_board u_brd (.*);
  // **************
  // Clock and jobs
  // **************
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Zero wait states today, but the wait stays open-ended up to a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    err_count += int'(n >= 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic t_par;
    for (int v = 0; v < 2; v++) begin
      reference_source_choice <= v[0];
      chan_b_enable_n <= v[0];
      u_brd.set_par(1'b0, v[0]);
      chk({dout_a, dout_b}, {v[0], 11'h5a3, v[0], 11'h0c1});
      chk({dout_a_oe, dout_b_oe}, {!v[0], !v[0]});
      chk({powerdown, use_internal_ref}, {v[0], v[0]});
      apb(1'b0, REG_STATUS, 32'h0, q, e);
      chk(q, v[0] ? 32'h3e : 32'h0);
    end
  endtask
  task automatic t_ser;
    u_brd.set_par(1'b1, 1'b0);
    u_brd.frame(16'h0007, 16);
    apb(1'b0, REG_STATUS, 32'h0, q, e);
    chk(q, 32'h3f);
    chk(dout_a_oe, 1'b0);
    chk({dout_a, powerdown}, {12'hda3, 1'b1});
    u_brd.frame(16'h0000, 8);
    apb(1'b0, REG_STATUS, 32'h0, q, e);
    chk(q, 32'h3f);
    u_brd.frame(16'h0002, 16);
    apb(1'b0, REG_STATUS, 32'h0, q, e);
    chk(q, 32'h2d);
    apb(1'b0, REG_SERIAL_WORD, 32'h0, q, e);
    chk(q, 32'h2);
    u_brd.set_par(1'b0, 1'b0);
    u_brd.set_par(1'b1, 1'b0);
    apb(1'b0, REG_STATUS, 32'h0, q, e);
    chk(q, 32'h29);
  endtask
  task automatic t_apb;
    apb(1'b1, REG_CONTROL, 32'h1, q, e);
    // New converter word must not reach the pins while frozen
    core_data_a <= 12'h123;
    repeat (3) @(posedge pclk);
    chk(dout_a, 12'h5a3);
    apb(1'b0, REG_CONTROL, 32'h0, q, e);
    chk(q, 32'h1);
    apb(1'b0, 8'h0c, 32'h0, q, e);
    chk({e, q[30:0]}, 32'h80000000);
    apb(1'b1, REG_STATUS, 32'h3f, q, e);
    chk(e, 1'b1);
    apb(1'b1, REG_CONTROL, 32'h0, q, e);
    repeat (3) @(posedge pclk);
    chk(dout_a, 12'h123);
  endtask
  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {presetn, reference_source_choice, chan_b_enable_n} = '0;
    core_data_a = 12'h5a3;
    core_data_b = 12'h0c1;
    err_count = 0;
    n_checks = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_par();
    t_ser();
    t_apb();
    report_and_stop();
  end
  // Watchdog well beyond the few hundred cycles the jobs need
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    report_and_stop();
  end
endmodule
